/* File: dv/testbench.sv */
// testbench: register checks for the channel-1 calibration bank
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench import cal_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [5:0] a; logic [15:0] rst; logic [15:0] wd; logic [15:0] rb;} row_t;
  localparam row_t ROWS [6] = '{'{6'h0F, 16'h0000, 16'hABCD, 16'hABCD},
    '{6'h10, 16'h0000, 16'h5AFF, 16'h5A00}, '{6'h11, 16'h8000, 16'h1234, 16'h1234},
    '{6'h12, 16'h0000, 16'hC3A5, 16'hC300}, '{6'h3E, 16'h0000, 16'hFFFF, 16'h0000},
    '{6'h3F, 16'h0000, 16'h0000, 16'h0000}};
  logic        ref_clk = 0, arst_n = 0, en = 1, wr = 0, rd = 0, crc_load = 0, hit;
  logic [5:0]  addr = '0;
  logic [15:0] wdata = '0, crc_val = '0, rdata;
  logic [23:0] ofs, gn;
  int          fail_count = 0, check_count = 0;
  cal_regs dut (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .clk_en_i(en), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit),
    .crc_load_i(crc_load), .crc_value_i(crc_val), .chan1_offset_o(ofs), .chan1_gain_o(gn));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(negedge ref_clk); addr = a; wdata = d; wr = 1;
    @(negedge ref_clk); wr = 0;
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(negedge ref_clk); addr = a; rd = 1;
    @(negedge ref_clk); rd = 0;
  endtask
  initial begin
    #(400 * 50);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1;
    `CHK(gn, 24'h800000)
    `CHK(ofs, 24'h000000)
    foreach (ROWS[i]) begin
      rd_reg(ROWS[i].a);
      `CHK(rdata, ROWS[i].rst)
      wr_reg(ROWS[i].a, ROWS[i].wd);
      rd_reg(ROWS[i].a);
      `CHK({hit, rdata}, {1'h1, ROWS[i].rb})
    end
    `CHK(ofs, 24'hABCD5A)
    `CHK(gn, 24'h1234C3)
    $display("test register_rows done");
    @(negedge ref_clk); crc_load = 1; crc_val = 16'h1E2D;
    @(negedge ref_clk); crc_load = 0;
    wr_reg(6'h3E, 16'h0000);
    rd_reg(6'h3E);
    `CHK(rdata, 16'h1E2D)
    $display("test checksum done");
    rd_reg(6'h20);
    `CHK({hit, rdata}, {1'h0, 16'h0000})
    en = 0;
    wr_reg(6'h0F, 16'h1111);
    en = 1;
    rd_reg(6'h0F);
    `CHK(rdata, 16'hABCD)
    wr_reg(6'h12, 16'hFFFF);
    rd_reg(6'h12);
    `CHK(rdata, 16'hFF00)
    $display("test awkward_cases done");
    @(negedge ref_clk); arst_n = 0;
    @(negedge ref_clk);
    `CHK(gn, 24'h800000)
    `CHK(ofs, 24'h000000)
    arst_n = 1;
    rd_reg(6'h11);
    `CHK(rdata, 16'h8000)
    rd_reg(6'h10);
    `CHK(rdata, 16'h0000)
    $display("test mid_reset done");
    stop_test();
  end
endmodule

/* File: hw/cal_regs.sv */
// module: channel-1 offset/gain calibration, checksum and reserved registers
//
// Function
// - offset word bits 23:8 held fully read/write at address 0Fh.
// - offset word bits 7:0 held read/write in bits 15:8 at address 10h.
// - gain word bits 23:8 held fully read/write at address 11h.
// - gain word bits 7:0 held read/write in bits 15:8 at address 12h.
// - upper gain register resets to 8000h.
// - both offset registers reset to 0000h.
// - low byte of lower calibration registers reads zero; register resets 0000h.
// - checksum at 3Eh is read-only, reads 0000h after reset.
module cal_regs
  import cal_regs_pkg::*;
(
  // clock, reset, enable
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              clk_en_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic                   reg_hit_o,
  // checksum source from map checker
  input  wire logic              crc_load_i,
  input  wire logic [DATA_W-1:0] crc_value_i,
  // calibration words to datapath
  output logic      [23:0]       chan1_offset_o,
  output logic      [23:0]       chan1_gain_o
);

  // ****************************************
  // address decode
  // ****************************************
  logic [15:0] ofs_hi_q;
  logic [7:0]  ofs_lo_q;
  logic [15:0] gn_hi_q;
  logic [7:0]  gn_lo_q;
  logic [15:0] crc_q;
  logic [15:0] rsvd_q;
  logic [15:0] rdata_d;
  logic        hit_d;

  wire sel_ofs_hi = reg_addr_i == OFS_CAL_HI_ADR;
  wire sel_ofs_lo = reg_addr_i == OFS_CAL_LO_ADR;
  wire sel_gn_hi  = reg_addr_i == GN_CAL_HI_ADR;
  wire sel_gn_lo  = reg_addr_i == GN_CAL_LO_ADR;
  wire sel_crc    = reg_addr_i == CHECKSUM_ADR;
  wire sel_rsvd   = reg_addr_i == RSVD_SLOT_ADR;
  wire [7:0] wr_hi_byte = reg_wdata_i[15:LOW_FIELD_LSB];

  assign hit_d = sel_ofs_hi | sel_ofs_lo | sel_gn_hi | sel_gn_lo | sel_crc | sel_rsvd;

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ofs_hi_q <= OFS_HI_RST;
      ofs_lo_q <= OFS_LO_RST;
      gn_hi_q  <= GN_HI_RST;
      gn_lo_q  <= GN_LO_RST;
      rsvd_q   <= RSVD_SLOT_RST;
    end else if (clk_en_i && reg_wr_i) begin
      if (sel_ofs_hi) ofs_hi_q <= reg_wdata_i;
      if (sel_ofs_lo) ofs_lo_q <= wr_hi_byte;
      if (sel_gn_hi)  gn_hi_q  <= reg_wdata_i;
      if (sel_gn_lo)  gn_lo_q  <= wr_hi_byte;
      if (sel_rsvd)   rsvd_q   <= reg_wdata_i;
    end
  end

  // checksum only follows the checker, never the register port
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc_q <= CHECKSUM_RST;
    end else if (clk_en_i && crc_load_i) begin
      crc_q <= crc_value_i;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // selects are exclusive; unmapped addresses read zero
  assign rdata_d = sel_ofs_hi ? ofs_hi_q                  :
                   sel_ofs_lo ? {ofs_lo_q, RSVD_BITS_VAL} :
                   sel_gn_hi  ? gn_hi_q                   :
                   sel_gn_lo  ? {gn_lo_q, RSVD_BITS_VAL}  :
                   sel_crc    ? crc_q                     :
                   sel_rsvd   ? rsvd_q                    :
                   16'h0000;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o    <= 16'h0000;
      reg_hit_o      <= 1'h0;
      chan1_offset_o <= {OFS_HI_RST, OFS_LO_RST};
      chan1_gain_o   <= {GN_HI_RST, GN_LO_RST};
    end else if (clk_en_i) begin
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
        reg_hit_o   <= hit_d;
      end
      chan1_offset_o <= {ofs_hi_q, ofs_lo_q};
      chan1_gain_o   <= {gn_hi_q, gn_lo_q};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_ofs_hi_wr;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && sel_ofs_hi |=> ofs_hi_q == $past(reg_wdata_i);
  endproperty
  a_ofs_hi_wr: assert property (p_ofs_hi_wr) else $error("offset high write lost");

  property p_ofs_lo_wr;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && sel_ofs_lo ##1 clk_en_i
      |=> chan1_offset_o[7:0] == $past(reg_wdata_i[15:8], 2);
  endproperty
  a_ofs_lo_wr: assert property (p_ofs_lo_wr) else $error("offset low byte wrong");

  property p_gn_hi_wr;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && sel_gn_hi ##1 clk_en_i
      |=> chan1_gain_o[23:8] == $past(reg_wdata_i, 2);
  endproperty
  a_gn_hi_wr: assert property (p_gn_hi_wr) else $error("gain high word wrong");

  property p_gn_lo_wr;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && sel_gn_lo |=> gn_lo_q == $past(reg_wdata_i[15:8]);
  endproperty
  a_gn_lo_wr: assert property (p_gn_lo_wr) else $error("gain low byte wrong");

  property p_gn_rst;
    @(posedge ref_clk_i) $rose(arst_n_i) |-> gn_hi_q == 16'h8000;
  endproperty
  a_gn_rst: assert property (p_gn_rst) else $error("gain high reset value wrong");

  property p_ofs_rst;
    @(posedge ref_clk_i) $rose(arst_n_i) |-> ofs_hi_q == 16'h0000 && ofs_lo_q == 8'h00;
  endproperty
  a_ofs_rst: assert property (p_ofs_rst) else $error("offset reset value wrong");

  property p_low_rsvd;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_rd_i && (sel_ofs_lo || sel_gn_lo) |=> reg_rdata_o[7:0] == 8'h00;
  endproperty
  a_low_rsvd: assert property (p_low_rsvd) else $error("reserved low byte not zero");

  property p_crc_ro;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      !crc_load_i |=> $stable(crc_q);
  endproperty
  a_crc_ro: assert property (p_crc_ro) else $error("checksum changed without load");

  property p_crc_read;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_rd_i && sel_crc |=> reg_rdata_o == $past(crc_q);
  endproperty
  a_crc_read: assert property (p_crc_read) else $error("checksum read wrong");

  property p_ofs_lo_q;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && sel_ofs_lo |=> ofs_lo_q == $past(reg_wdata_i[15:8]);
  endproperty
  a_ofs_lo_q: assert property (p_ofs_lo_q) else $error("offset low byte write lost");

  property p_gn_hi_q;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && sel_gn_hi |=> gn_hi_q == $past(reg_wdata_i);
  endproperty
  a_gn_hi_q: assert property (p_gn_hi_q) else $error("gain high write lost");

  property p_ofs_hi_rd;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_rd_i && sel_ofs_hi |=> reg_rdata_o == $past(ofs_hi_q);
  endproperty
  a_ofs_hi_rd: assert property (p_ofs_hi_rd) else $error("offset high read wrong");

  property p_gn_lo_rd;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_rd_i && sel_gn_lo |=> reg_rdata_o[15:8] == $past(gn_lo_q);
  endproperty
  a_gn_lo_rd: assert property (p_gn_lo_rd) else $error("gain low read wrong");

  property p_gn_out_rst;
    @(posedge ref_clk_i) $rose(arst_n_i) |-> chan1_gain_o == 24'h800000;
  endproperty
  a_gn_out_rst: assert property (p_gn_out_rst) else $error("gain word reset wrong");

  property p_ofs_out_rst;
    @(posedge ref_clk_i) $rose(arst_n_i) |-> chan1_offset_o == 24'h000000;
  endproperty
  a_ofs_out_rst: assert property (p_ofs_out_rst) else $error("offset word reset wrong");

  property p_low_rst;
    @(posedge ref_clk_i) $rose(arst_n_i) |-> gn_lo_q == 8'h00;
  endproperty
  a_low_rst: assert property (p_low_rst) else $error("gain low reset wrong");

  property p_crc_rst;
    @(posedge ref_clk_i) $rose(arst_n_i) |-> crc_q == 16'h0000;
  endproperty
  a_crc_rst: assert property (p_crc_rst) else $error("checksum reset wrong");

  property p_en_freeze;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      !clk_en_i |=> $stable(gn_hi_q) && $stable(ofs_hi_q) && $stable(reg_rdata_o);
  endproperty
  a_en_freeze: assert property (p_en_freeze) else $error("state moved with enable low");

  c_gn_write: cover property (@(posedge ref_clk_i) clk_en_i && reg_wr_i && sel_gn_hi);
  c_ofs_read: cover property (@(posedge ref_clk_i) clk_en_i && reg_rd_i && sel_ofs_lo);
  c_crc_load: cover property (@(posedge ref_clk_i) clk_en_i && crc_load_i);
  c_miss:     cover property (@(posedge ref_clk_i) clk_en_i && reg_rd_i && !hit_d);

endmodule

/* File: hw/cal_regs_pkg.sv */
// package: register map constants for the channel-1 calibration bank
package cal_regs_pkg;
  localparam int unsigned ADDR_W         = 6;
  localparam int unsigned DATA_W         = 16;
  localparam logic [5:0]  OFS_CAL_HI_ADR = 6'h0F;
  localparam logic [5:0]  OFS_CAL_LO_ADR = 6'h10;
  localparam logic [5:0]  GN_CAL_HI_ADR  = 6'h11;
  localparam logic [5:0]  GN_CAL_LO_ADR  = 6'h12;
  localparam logic [5:0]  CHECKSUM_ADR   = 6'h3E;
  localparam logic [5:0]  RSVD_SLOT_ADR  = 6'h3F;
  localparam logic [15:0] OFS_HI_RST     = 16'h0000;
  localparam logic [7:0]  OFS_LO_RST     = 8'h00;
  localparam logic [15:0] GN_HI_RST      = 16'h8000;
  localparam logic [7:0]  GN_LO_RST      = 8'h00;
  localparam logic [15:0] CHECKSUM_RST   = 16'h0000;
  localparam logic [15:0] RSVD_SLOT_RST  = 16'h0000;
  localparam int unsigned LOW_FIELD_LSB  = 8;
  localparam logic [7:0]  RSVD_BITS_VAL  = 8'h00;
endpackage
